// ==== rtl/asf_params.svh ====
// Constants of the serial audio framing port: offsets, fields, reset values.
// Assumes a byte-addressed port, one 32-bit word per register.
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH
// Register offsets
`define ASF_OFS_GLOBAL 8'h00
`define ASF_OFS_CLOCK 8'h04
`define ASF_OFS_SLOTS 8'h08
`define ASF_OFS_WARN 8'h0C
`define ASF_OFS_STATUS 8'h10
`define ASF_OFS_TXFIFO 8'h14
`define ASF_OFS_RXFIFO 8'h18
`define ASF_OFS_TXDMA 8'h20
`define ASF_OFS_RXDMA 8'h30
// global_config fields
`define ASF_GC_EN 0
`define ASF_GC_MASTER 1
`define ASF_GC_NET 2
`define ASF_GC_W16 3
`define ASF_GC_SCS_LO 4
`define ASF_GC_LONG 6
`define ASF_GC_FSL_LO 7
`define ASF_GC_PLL 10
// clock_control_reg fields
`define ASF_CC_BCD_LO 0
`define ASF_CC_FCD_LO 8
// Reset values
`define ASF_RST_GLOBAL 11'h002
`define ASF_RST_BCD 8'h2E
`define ASF_RST_FCD 7'h1F
`define ASF_RST_WARN 5'h04
// Long frame sync lengths
`define ASF_FSL_6 7'h06
`define ASF_FSL_13 7'h0D
`define ASF_FSL_14 7'h0E
`define ASF_FSL_15 7'h0F
`define ASF_FSL_16 7'h10
`endif

// ==== rtl/asf_pkg.sv ====
// Types shared by the serial audio framing port.
// Assumes asf_params.svh supplies the numeric constants.
package asf_pkg;
  typedef logic [15:0] asf_word_t;
  typedef logic [6:0] asf_bitpos_t;
  typedef logic [3:0] asf_slot_t;
  typedef enum logic [2:0] {ASF_FSL_SIX = 3'h0, ASF_FSL_THIRTEEN = 3'h1, ASF_FSL_FOURTEEN = 3'h2,
                            ASF_FSL_FIFTEEN = 3'h3, ASF_FSL_SIXTEEN = 3'h4} asf_fsl_e;
endpackage

// ==== rtl/asf_audio_port.sv ====
// Serial audio port framing: clocks, sync, slots, FIFOs, DMA holding registers.
// Assumes one system clock; shift clock edges are events in it; pins synchronised here.
// Notes on behaviour
// - receive and transmit share one shift clock and frame sync from common prescalers.
// - normal mode: frame sync rising edge starts frame and its single slot.
// - receiver keeps only bits after frame sync; word to FIFO or DMA register zero.
// - transmit data pin driven only while word bits shift; released afterwards.
// - receive FIFO request when fill count exceeds warning limit; held low here while the overrun flag is set.
// - transmit FIFO request when available entries at or below warning limit; held low here while the underrun flag is set.
// - normal mode receive DMA: request while register zero holds unread word.
// - normal mode transmit DMA: request while register zero empty.
// - network mode: sync marks frame start; up to four equal 8/16-bit slots.
// - one master drives shift clock and frame sync; others take them as inputs.
// - transmitter drives only in assigned slots, high impedance elsewhere.
// - each transmit slot sources from FIFO or its own DMA register.
// - receiver stores only assigned slots, into FIFO or per-slot DMA register.
// - per-slot DMA request: receive register full, transmit register empty.
// - spare receive clock pin pulses at slot 1, receive sync pin at slot 2.
// - bit clock divides selected input clock by divider field plus one.
// - input clocks are 12 MHz auxiliary tick or 48 MHz PLL tick.
// - frame clock divides bit clock by frame divider plus one.
// - long frame sync length selectable as 6, 13, 14, 15 or 16 bits.
// - transmit changes on shift clock rise, receive samples on fall.
// - words shift most significant bit first.
// - empty transmit DMA register at word time resends that slot's last word.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "asf_params.svh"
module asf_audio_port #(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW = 4
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic aux_clk_tick, // Auxiliary input clock event
  input wire logic pll_clk_tick, // PLL input clock event
  input wire logic shift_clk_i, // Shift clock pin level
  output logic shift_clk_o, // Shift clock pin drive
  output logic shift_clk_oe, // Shift clock pin enable
  input wire logic tx_frame_sync_i, // Frame sync pin level
  output logic tx_frame_sync_o, // Frame sync pin drive
  output logic tx_frame_sync_oe, // Frame sync pin enable
  output logic serial_tx_data, // Transmit data drive
  output logic serial_tx_data_oe, // Transmit data enable
  input wire logic serial_rx_data, // Receive data pin
  output logic rx_shift_clock_pin_o, // Slot 1 sync drive
  output logic rx_shift_clock_pin_oe, // Slot 1 sync enable
  output logic rx_frame_sync_pin_o, // Slot 2 sync drive
  output logic rx_frame_sync_pin_oe, // Slot 2 sync enable
  output logic rx_fifo_irq, // Receive FIFO warning level
  output logic tx_fifo_irq, // Transmit FIFO warning level
  output logic [3:0] rx_dma_req, // Per-slot receive DMA request
  output logic [3:0] tx_dma_req // Per-slot transmit DMA request
);

  // Long frame sync length from the length code
  function automatic asf_pkg::asf_bitpos_t fs_len(input logic [2:0] code);
    unique case (asf_pkg::asf_fsl_e'(code))
      asf_pkg::ASF_FSL_SIX: fs_len = `ASF_FSL_6;
      asf_pkg::ASF_FSL_THIRTEEN: fs_len = `ASF_FSL_13;
      asf_pkg::ASF_FSL_FOURTEEN: fs_len = `ASF_FSL_14;
      asf_pkg::ASF_FSL_FIFTEEN: fs_len = `ASF_FSL_15;
      default: fs_len = `ASF_FSL_16;
    endcase
  endfunction

  // Slot index of a bit position
  function automatic asf_pkg::asf_slot_t slot_of(input asf_pkg::asf_bitpos_t pos, input logic w16);
    slot_of = w16 ? {1'b0, pos[6:4]} : pos[6:3];
  endfunction

  // Bit index inside its slot
  function automatic logic [3:0] bit_of(input asf_pkg::asf_bitpos_t pos, input logic w16);
    bit_of = w16 ? pos[3:0] : {1'b0, pos[2:0]};
  endfunction

  // Mask bit of a slot, zero beyond slot 3
  function automatic logic sel_of(input logic [3:0] mask, input asf_pkg::asf_slot_t s);
    sel_of = (s < 4'h4) && mask[s[1:0]];
  endfunction

  logic rst_meta;
  logic rst_s_n;
  logic [10:0] gcfg;
  logic [7:0] bc_div;
  logic [6:0] fc_div;
  logic [3:0] tx_sa;
  logic [3:0] rx_sa;
  logic [3:0] tx_ds;
  logic [3:0] rx_ds;
  logic [4:0] rx_warn;
  logic [4:0] tx_warn;
  logic [2:0] sy1;
  logic [2:0] sy2;
  logic sck_d3;
  logic [7:0] pre_cnt;
  logic [6:0] fr_cnt;
  logic fs_prev;
  logic frame_ok;
  asf_pkg::asf_bitpos_t bit_pos;
  logic [15:0] tx_sr;
  logic [15:0] rx_sr;
  logic [15:0] tx_mem [FIFO_DEPTH];
  logic [15:0] rx_mem [FIFO_DEPTH];
  logic [FIFO_AW:0] tx_wp;
  logic [FIFO_AW:0] tx_rp;
  logic [FIFO_AW:0] rx_wp;
  logic [FIFO_AW:0] rx_rp;
  asf_pkg::asf_word_t tx_dma [4];
  asf_pkg::asf_word_t tx_last [4];
  asf_pkg::asf_word_t tx_fifo_last;
  asf_pkg::asf_word_t rx_dma [4];
  logic rx_ovr;
  logic tx_und;

  wire logic cfg_en = gcfg[`ASF_GC_EN];
  wire logic cfg_master = gcfg[`ASF_GC_MASTER];
  wire logic cfg_net = gcfg[`ASF_GC_NET];
  wire logic cfg_w16 = gcfg[`ASF_GC_W16];
  wire logic cfg_long = gcfg[`ASF_GC_LONG];
  wire logic [2:0] cfg_fsl = gcfg[`ASF_GC_FSL_LO +: 3];
  wire logic [2:0] n_slots = cfg_net ? {1'b0, gcfg[`ASF_GC_SCS_LO +: 2]} + 3'h1 : 3'h1;
  wire logic sel_tick = gcfg[`ASF_GC_PLL] ? pll_clk_tick : aux_clk_tick;
  wire logic [FIFO_AW:0] tx_cnt = tx_wp - tx_rp;
  wire logic [FIFO_AW:0] rx_cnt = rx_wp - rx_rp;
  wire logic tx_empty = (tx_cnt == '0);
  wire logic rx_full = (rx_cnt == (FIFO_AW + 1)'(FIFO_DEPTH));
  wire logic tx_full = (tx_cnt == (FIFO_AW + 1)'(FIFO_DEPTH));

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_s_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_s_n <= rst_meta;
    end
  end

  // Two-stage pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      sy1 <= 3'h0;
      sy2 <= 3'h0;
      sck_d3 <= 1'b0;
    end
    else
    begin
      sy1 <= {serial_rx_data, tx_frame_sync_i, shift_clk_i};
      sy2 <= sy1;
      sck_d3 <= sy2[0];
    end
  end

  // Shift clock events: prescaler as master, pin edges as slave
  wire logic rise_ev = cfg_en && (cfg_master ? sel_tick && pre_cnt == bc_div : sy2[0] && !sck_d3);
  wire logic fall_ev = cfg_en && (cfg_master ? sel_tick && pre_cnt == (bc_div >> 1) : !sy2[0] && sck_d3);

  // Bit clock prescaler, divide by field plus one
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
      pre_cnt <= 8'h00;
    else if (!cfg_en || !cfg_master)
      pre_cnt <= 8'h00;
    else if (sel_tick)
      pre_cnt <= (pre_cnt == bc_div) ? 8'h00 : pre_cnt + 8'h01;
  end

  // Frame prescaler and frame sync as master
  wire logic [6:0] next_fr_cnt = (fr_cnt == fc_div) ? 7'h00 : fr_cnt + 7'h01;
  wire logic next_fs_int = cfg_long ? (next_fr_cnt < fs_len(cfg_fsl)) : (next_fr_cnt == 7'h00);
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      fr_cnt <= 7'h7F;
      shift_clk_o <= 1'b0;
      tx_frame_sync_o <= 1'b0;
      shift_clk_oe <= 1'b0;
      tx_frame_sync_oe <= 1'b0;
    end
    else
    begin
      shift_clk_oe <= cfg_en && cfg_master;
      tx_frame_sync_oe <= cfg_en && cfg_master;
      if (!cfg_en || !cfg_master)
      begin
        fr_cnt <= fc_div;
        shift_clk_o <= 1'b0;
        tx_frame_sync_o <= 1'b0;
      end
      else if (rise_ev)
      begin
        fr_cnt <= next_fr_cnt;
        shift_clk_o <= 1'b1;
        tx_frame_sync_o <= next_fs_int;
      end
      else if (fall_ev)
        shift_clk_o <= 1'b0;
    end
  end

  // Frame start and bit position, shared by both paths
  wire logic fs_now = cfg_master ? next_fs_int : sy2[1];
  wire logic fstart = rise_ev && fs_now && !fs_prev;
  wire asf_pkg::asf_bitpos_t next_bit_pos = fstart ? 7'h00 : (bit_pos == 7'h7F) ? 7'h7F : bit_pos + 7'h01;
  wire asf_pkg::asf_slot_t nx_slot = slot_of(next_bit_pos, cfg_w16);
  wire logic [3:0] nx_bit = bit_of(next_bit_pos, cfg_w16);
  wire logic nx_in = (frame_ok || fstart) && ({1'b0, nx_slot} < {2'b00, n_slots});
  wire asf_pkg::asf_slot_t cu_slot = slot_of(bit_pos, cfg_w16);
  wire logic cu_in = frame_ok && ({1'b0, cu_slot} < {2'b00, n_slots});
  wire logic cu_last = (bit_of(bit_pos, cfg_w16) == (cfg_w16 ? 4'hF : 4'h7));
  wire asf_pkg::asf_slot_t cu_next = cu_slot + 4'h1;
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      fs_prev <= 1'b0;
      frame_ok <= 1'b0;
      bit_pos <= 7'h7F;
    end
    else if (!cfg_en)
    begin
      fs_prev <= 1'b0;
      frame_ok <= 1'b0;
      bit_pos <= 7'h7F;
    end
    else if (rise_ev)
    begin
      fs_prev <= fs_now;
      bit_pos <= next_bit_pos;
      if (fstart)
        frame_ok <= 1'b1;
    end
  end

  // Transmit word source for the slot about to start
  wire logic tx_load = rise_ev && nx_in && sel_of(tx_sa, nx_slot) && (nx_bit == 4'h0);
  wire logic tx_use_dma = sel_of(tx_ds, nx_slot);
  wire logic [15:0] tx_word = tx_use_dma ? (tx_dma_req[nx_slot[1:0]] ? tx_last[nx_slot[1:0]] : tx_dma[nx_slot[1:0]])
    : (tx_empty ? tx_fifo_last : tx_mem[tx_rp[FIFO_AW-1:0]]);
  wire logic [15:0] tx_aligned = cfg_w16 ? tx_word : {tx_word[7:0], 8'h00};

  // Transmit serializer and data pin enable
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      tx_sr <= 16'h0000;
      serial_tx_data <= 1'b0;
      serial_tx_data_oe <= 1'b0;
    end
    else if (!cfg_en)
      serial_tx_data_oe <= 1'b0;
    else if (rise_ev)
    begin
      if (nx_in && sel_of(tx_sa, nx_slot))
      begin
        serial_tx_data_oe <= 1'b1;
        if (nx_bit == 4'h0)
        begin
          tx_sr <= tx_aligned;
          serial_tx_data <= tx_aligned[15];
        end
        else
        begin
          tx_sr <= {tx_sr[14:0], 1'b0};
          serial_tx_data <= tx_sr[14];
        end
      end
      else
        serial_tx_data_oe <= 1'b0;
    end
    else if (fall_ev && cu_in && cu_last && !(({1'b0, cu_next} < {2'b00, n_slots}) && sel_of(tx_sa, cu_next)))
      serial_tx_data_oe <= 1'b0;
  end

  // Transmit FIFO read side and retransmit memory
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      tx_rp <= '0;
      tx_fifo_last <= 16'h0000;
      tx_und <= 1'b0;
      for (int i = 0; i < 4; i++)
        tx_last[i] <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == `ASF_OFS_STATUS && reg_wdata[1])
        tx_und <= 1'b0;
      if (tx_load)
      begin
        tx_last[nx_slot[1:0]] <= tx_word;
        if (!tx_use_dma)
        begin
          tx_fifo_last <= tx_word;
          if (tx_empty)
            tx_und <= 1'b1; // Set wins over clear
          else
            tx_rp <= tx_rp + 1'b1;
        end
      end
    end
  end

  // Transmit DMA holding registers; request while a slot's register is empty
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      tx_dma_req <= 4'h0;
      for (int i = 0; i < 4; i++)
        tx_dma[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (reg_wr && reg_addr == (`ASF_OFS_TXDMA + 8'(4 * i)))
        begin
          tx_dma[i] <= reg_wdata[15:0];
          tx_dma_req[i] <= 1'b0;
        end
        else if (tx_load && tx_use_dma && nx_slot[1:0] == 2'(i))
          tx_dma_req[i] <= 1'b1;
        else if (!cfg_en || !tx_ds[i])
          tx_dma_req[i] <= 1'b0;
      end
    end
  end

  // Receive deserializer on falling shift clock
  wire logic rx_take = fall_ev && cu_in && sel_of(rx_sa, cu_slot);
  wire logic [15:0] rx_word_raw = {rx_sr[14:0], sy2[2]};
  wire logic [15:0] rx_word = cfg_w16 ? rx_word_raw : {8'h00, rx_word_raw[7:0]};
  wire logic rx_done = rx_take && cu_last;
  wire logic rx_to_dma = sel_of(rx_ds, cu_slot);
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_sr <= 16'h0000;
      rx_wp <= '0;
      for (int i = 0; i < 4; i++)
        rx_dma[i] <= 16'h0000;
    end
    else if (rx_take)
    begin
      rx_sr <= rx_word_raw;
      if (rx_done && rx_to_dma)
        rx_dma[cu_slot[1:0]] <= rx_word;
      else if (rx_done && !rx_full)
      begin
        rx_mem[rx_wp[FIFO_AW-1:0]] <= rx_word;
        rx_wp <= rx_wp + 1'b1;
      end
    end
  end

  // Receive DMA full flags and overrun flag; set wins over clear
  wire logic rd_rxdma = reg_rd && (reg_addr[7:4] == `ASF_OFS_RXDMA >> 4) && (reg_addr[1:0] == 2'b00);
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_dma_req <= 4'h0;
      rx_ovr <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (rx_done && rx_to_dma && cu_slot[1:0] == 2'(i))
          rx_dma_req[i] <= 1'b1;
        else if ((rd_rxdma && reg_addr[3:2] == 2'(i)) || !rx_ds[i])
          rx_dma_req[i] <= 1'b0;
      end
      if (rx_done && !rx_to_dma && rx_full)
        rx_ovr <= 1'b1;
      else if (reg_wr && reg_addr == `ASF_OFS_STATUS && reg_wdata[0])
        rx_ovr <= 1'b0;
    end
  end

  // FIFO warning levels
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_fifo_irq <= 1'b0;
      tx_fifo_irq <= 1'b0;
    end
    else
    begin
      rx_fifo_irq <= cfg_en && (rx_cnt > rx_warn) && !rx_ovr;
      tx_fifo_irq <= cfg_en && (tx_cnt <= tx_warn) && !tx_und;
    end
  end

  // Spare receive pins pulse at slots 1 and 2 in network mode
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rx_shift_clock_pin_o <= 1'b0;
      rx_frame_sync_pin_o <= 1'b0;
      rx_shift_clock_pin_oe <= 1'b0;
      rx_frame_sync_pin_oe <= 1'b0;
    end
    else
    begin
      rx_shift_clock_pin_oe <= cfg_en && cfg_net;
      rx_frame_sync_pin_oe <= cfg_en && cfg_net;
      if (!cfg_en || !cfg_net)
      begin
        rx_shift_clock_pin_o <= 1'b0;
        rx_frame_sync_pin_o <= 1'b0;
      end
      else if (rise_ev)
      begin
        rx_shift_clock_pin_o <= nx_in && nx_slot == 4'h1 && nx_bit == 4'h0;
        rx_frame_sync_pin_o <= nx_in && nx_slot == 4'h2 && nx_bit == 4'h0;
      end
    end
  end

  // Register writes and transmit FIFO fill
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      gcfg <= `ASF_RST_GLOBAL;
      bc_div <= `ASF_RST_BCD;
      fc_div <= `ASF_RST_FCD;
      {rx_ds, tx_ds, rx_sa, tx_sa} <= 16'h0011;
      rx_warn <= `ASF_RST_WARN;
      tx_warn <= `ASF_RST_WARN;
      tx_wp <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `ASF_OFS_GLOBAL: gcfg <= reg_wdata[10:0];
        `ASF_OFS_CLOCK:
        begin
          bc_div <= reg_wdata[`ASF_CC_BCD_LO +: 8];
          fc_div <= reg_wdata[`ASF_CC_FCD_LO +: 7];
        end
        `ASF_OFS_SLOTS: {rx_ds, tx_ds, rx_sa, tx_sa} <= reg_wdata[15:0];
        `ASF_OFS_WARN:
        begin
          rx_warn <= reg_wdata[4:0];
          tx_warn <= reg_wdata[12:8];
        end
        `ASF_OFS_TXFIFO:
          if (!tx_full)
          begin
            tx_mem[tx_wp[FIFO_AW-1:0]] <= reg_wdata[15:0];
            tx_wp <= tx_wp + 1'b1;
          end
        default: ;
      endcase
    end
  end

  // Register reads and receive FIFO drain
  always_ff @(posedge clk_sys or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      reg_rdata <= 32'h0000_0000;
      rx_rp <= '0;
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        if (reg_addr == `ASF_OFS_GLOBAL)
          reg_rdata <= {21'h0, gcfg};
        else if (reg_addr == `ASF_OFS_CLOCK)
          reg_rdata <= {17'h0, fc_div, bc_div};
        else if (reg_addr == `ASF_OFS_SLOTS)
          reg_rdata <= {16'h0, rx_ds, tx_ds, rx_sa, tx_sa};
        else if (reg_addr == `ASF_OFS_WARN)
          reg_rdata <= {19'h0, tx_warn, 3'h0, rx_warn};
        else if (reg_addr == `ASF_OFS_STATUS)
          reg_rdata <= {17'h0, tx_cnt, 3'h0, rx_cnt, tx_und, rx_ovr};
        else if (reg_addr == `ASF_OFS_RXFIFO && rx_cnt != '0)
        begin
          reg_rdata <= {16'h0, rx_mem[rx_rp[FIFO_AW-1:0]]};
          rx_rp <= rx_rp + 1'b1;
        end
        else if (rd_rxdma)
          reg_rdata <= {16'h0, rx_dma[reg_addr[3:2]]};
        else if (reg_addr[7:4] == `ASF_OFS_TXDMA >> 4 && reg_addr[1:0] == 2'b00)
          reg_rdata <= {16'h0, tx_dma[reg_addr[3:2]]};
      end
    end
  end

endmodule // asf_audio_port

// ==== verification/asf_audio_port_assertions.sv ====
// Checker of the serial audio framing port, bound to its top.
// Assumes the port is shift clock master whenever frame timing is judged.
`timescale 1ns/10ps
`include "asf_params.svh"
module asf_audio_port_assertions (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic shift_clk_o, // Shift clock drive
  input wire logic shift_clk_oe, // Shift clock enable
  input wire logic tx_frame_sync_o, // Frame sync drive
  input wire logic tx_frame_sync_oe, // Frame sync enable
  input wire logic serial_tx_data, // Transmit data
  input wire logic serial_tx_data_oe, // Transmit enable
  input wire logic rx_shift_clock_pin_o, // Slot 1 sync
  input wire logic rx_frame_sync_pin_o, // Slot 2 sync
  input wire logic [3:0] rx_dma_req, // Receive DMA requests
  input wire logic [3:0] tx_dma_req // Transmit DMA requests
);
  logic clk_q, fs_q, seen;
  logic [6:0] fcd;
  logic [7:0] rises;
  wire fs_rise = tx_frame_sync_o && !fs_q;
  // Divider copy and rises per frame
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      {clk_q, fs_q, seen} <= 3'h0;
      fcd <= 7'h1F;
      rises <= 8'h00;
    end
    else
    begin
      clk_q <= shift_clk_o;
      fs_q <= tx_frame_sync_o;
      if (reg_wr && reg_addr == `ASF_OFS_CLOCK)
        fcd <= reg_wdata[14:8];
      if (fs_rise)
        rises <= 8'h01;
      else if (shift_clk_o && !clk_q)
        rises <= rises + 8'h01;
      if (fs_rise)
        seen <= 1'b1;
    end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_rxdma;
    reg_rd && reg_addr == `ASF_OFS_RXDMA;
  endsequence
  sequence s_wr_txdma;
    reg_wr && reg_addr == `ASF_OFS_TXDMA;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
  a_rdata_unmapped: assert property (reg_rd && reg_addr == 8'h1C |=> reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
  a_rxdma_clear: assert property (s_rd_rxdma |-> ##2 !rx_dma_req[0])
    else $error("rx request kept");
  a_txdma_clear: assert property (s_wr_txdma |-> ##2 !tx_dma_req[0])
    else $error("tx request kept");
  a_fs_with_clk: assert property ($rose(tx_frame_sync_o) && shift_clk_oe |-> $rose(shift_clk_o))
    else $error("sync off clock rise");
  a_frame_len: assert property (fs_rise && seen && shift_clk_oe |-> rises == {1'b0, fcd} + 8'h01)
    else $error("frame length wrong");
  a_tx_on_rise: assert property (serial_tx_data_oe && $changed(serial_tx_data) && shift_clk_oe |-> $rose(shift_clk_o))
    else $error("data off rise");
  a_oe_start: assert property ($rose(serial_tx_data_oe) && shift_clk_oe |-> $rose(shift_clk_o))
    else $error("tx enable rose off rise");
  a_oe_release: assert property ($fell(serial_tx_data_oe) && shift_clk_oe |-> $fell(shift_clk_o))
    else $error("tx enable fell off fall");
  a_pin_oe_pair: assert property (shift_clk_oe == tx_frame_sync_oe)
    else $error("pin enables differ");
  a_aux_excl: assert property (!(rx_shift_clock_pin_o && rx_frame_sync_pin_o))
    else $error("spare syncs overlap");
endmodule // asf_audio_port_assertions
bind asf_audio_port asf_audio_port_assertions chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_clk_o(shift_clk_o),
  .shift_clk_oe(shift_clk_oe), .tx_frame_sync_o(tx_frame_sync_o), .tx_frame_sync_oe(tx_frame_sync_oe),
  .serial_tx_data(serial_tx_data), .serial_tx_data_oe(serial_tx_data_oe),
  .rx_shift_clock_pin_o(rx_shift_clock_pin_o), .rx_frame_sync_pin_o(rx_frame_sync_pin_o),
  .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));

// ==== verification/asf_codec_model.sv ====
// Codec on the shared bus: answers each frame with one word, records what it hears.
// Assumes clock and sync come from the port, seen in the system clock.
`timescale 1ns/10ps
module asf_codec_model #(
  parameter logic [15:0] WORD = 16'hA5C3
) (
  input wire logic clk, // System clock
  input wire logic sclk, // Shift clock, input only
  input wire logic fs, // Frame sync, input only
  input wire logic sd_in, // Port transmit data
  input wire logic sd_oe, // Port transmit enable
  output logic sd_out, // Codec data to the port
  output logic [15:0] heard, // Last 16 bits heard
  output logic [7:0] first, // Bit index of first driven bit
  output logic [7:0] cnt // Driven bits in last frame
);
  logic sclk_q = 1'b0, fs_q = 1'b0, d_q = 1'b0, oe_q = 1'b0;
  logic [7:0] idx = 8'hFF, run = 8'h00;
  initial {sd_out, heard, first, cnt} = 33'h0;
  // Data moves on rises, listens on falls, noise once the word is out
  always @(posedge clk)
  begin
    if (!sclk_q && sclk)
    begin
      idx = (fs && !fs_q) ? 8'h00 : idx + 8'h01;
      if (idx == 8'h00)
        {cnt, run} = {run, 8'h00};
      sd_out <= (idx < 8'h10) ? WORD[4'(8'h0F - idx)] : ~sd_out;
    end
    if (sclk_q && !sclk && oe_q)
    begin
      heard = {heard[14:0], d_q};
      if (run == 8'h00)
        first = idx;
      run = run + 8'h01;
    end
    {sclk_q, fs_q, d_q, oe_q} = {sclk, fs, sd_in, sd_oe};
  end
endmodule // asf_codec_model

// ==== verification/asf_audio_port_tb.sv ====
// Self-checking bench of the serial audio framing port as master with one codec.
// Assumes an auxiliary tick every cycle, 8 cycles per bit.
`timescale 1ns/10ps
`include "asf_params.svh"
module asf_audio_port_tb;
  localparam logic [15:0] CODEC_WORD = 16'hA5C3;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic shift_clk_o, tx_frame_sync_o, serial_tx_data, serial_tx_data_oe, serial_rx_data, rx_fifo_irq;
  logic [3:0] rx_dma_req, tx_dma_req;
  logic [15:0] heard;
  logic [7:0] first, cnt;
  int bad_count = 0;
  int comparisons = 0;
  // Clock of 100 ns
  always #50 clk_sys = ~clk_sys;
  asf_audio_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_clk_tick(1'b1), .pll_clk_tick(1'b0),
    .shift_clk_i(1'b0), .shift_clk_o(shift_clk_o), .shift_clk_oe(), .tx_frame_sync_i(1'b0),
    .tx_frame_sync_o(tx_frame_sync_o), .tx_frame_sync_oe(), .serial_tx_data(serial_tx_data),
    .serial_tx_data_oe(serial_tx_data_oe), .serial_rx_data(serial_rx_data), .rx_shift_clock_pin_o(),
    .rx_shift_clock_pin_oe(), .rx_frame_sync_pin_o(), .rx_frame_sync_pin_oe(), .rx_fifo_irq(rx_fifo_irq),
    .tx_fifo_irq(), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
  asf_codec_model #(.WORD(CODEC_WORD)) codec_u (.clk(clk_sys), .sclk(shift_clk_o), .fs(tx_frame_sync_o),
    .sd_in(serial_tx_data), .sd_oe(serial_tx_data_oe), .sd_out(serial_rx_data), .heard(heard),
    .first(first), .cnt(cnt));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_reset_values();
    logic [31:0] d;
    rd(`ASF_OFS_GLOBAL, d);
    chk("global_config", 32'h002, d);
    rd(`ASF_OFS_CLOCK, d);
    chk("clock_control_reg", 32'h1F2E, d);
    rd(`ASF_OFS_SLOTS, d);
    chk("slot_assign_control", 32'h0011, d);
    rd(8'h1C, d);
    chk("unmapped", 32'h0, d);
  endtask
  task automatic t_normal_fifo();
    logic [31:0] d;
    wr(`ASF_OFS_CLOCK, 32'h1F07);
    wr(`ASF_OFS_TXFIFO, 32'h3C96);
    wr(`ASF_OFS_GLOBAL, 32'h00B);
    repeat (7 * 256) @(posedge clk_sys);
    chk("tx word", 32'h3C96, {16'h0, heard});
    chk("tx first bit", 32'h0, {24'h0, first});
    chk("tx bit count", 32'h10, {24'h0, cnt});
    chk("rx irq", 32'h1, {31'h0, rx_fifo_irq});
    rd(`ASF_OFS_RXFIFO, d);
    chk("rx fifo word", {16'h0, CODEC_WORD}, d);
  endtask
  task automatic t_dma();
    logic [31:0] d;
    wr(`ASF_OFS_CLOCK, 32'h1F07);
    wr(`ASF_OFS_SLOTS, 32'h3311);
    wr(`ASF_OFS_TXDMA, 32'h5A69);
    wr(`ASF_OFS_GLOBAL, 32'h00B);
    repeat (3 * 256) @(posedge clk_sys);
    chk("rx dma req", 32'h1, {31'h0, rx_dma_req[0]});
    chk("tx dma req", 32'h1, {31'h0, tx_dma_req[0]});
    chk("tx dma word", 32'h5A69, {16'h0, heard});
    rd(`ASF_OFS_RXDMA, d);
    chk("rx dma word", {16'h0, CODEC_WORD}, d);
  endtask
  task automatic t_network();
    logic [31:0] d;
    wr(`ASF_OFS_CLOCK, 32'h1F07);
    wr(`ASF_OFS_SLOTS, 32'h0022);
    wr(`ASF_OFS_TXFIFO, 32'h00E1);
    wr(`ASF_OFS_GLOBAL, 32'h037);
    repeat (3 * 256) @(posedge clk_sys);
    chk("slot 1 start", 32'h8, {24'h0, first});
    chk("slot bits", 32'h8, {24'h0, cnt});
    chk("slot word", 32'hE1, {24'h0, heard[7:0]});
    rd(`ASF_OFS_RXFIFO, d);
    chk("rx slot word", {24'h0, CODEC_WORD[7:0]}, d);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    do_reset();
    t_reset_values();
    t_normal_fifo();
    do_reset();
    t_dma();
    do_reset();
    t_network();
    print_verdict();
  end
  // Watchdog, nearly six times the expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule // asf_audio_port_tb
